// file: common/uebc_pkg.sv
package uebc_pkg;
	localparam int          UEBC_NUM_EP          = 5;
	localparam logic [7:0]  UEBC_ADDR_BUF_STATUS = 8'hc2;
	localparam logic [7:0]  UEBC_ADDR_BUF_CTRL   = 8'hc1;
	localparam logic [7:0]  UEBC_ADDR_BANK_SEL   = 8'hd2;
	localparam logic [7:0]  UEBC_ADDR_DATA_WIN   = 8'hc4;
	localparam logic [7:0]  UEBC_ADDR_OFFSET     = 8'hc5;
	localparam logic [7:0]  UEBC_RST_BUF_STATUS  = 8'h20;
	localparam logic [7:0]  UEBC_RST_BUF_CTRL    = 8'h00;
	localparam logic [7:0]  UEBC_RST_BANK_SEL    = 8'h00;
	localparam logic [7:0]  UEBC_RST_OFFSET      = 8'h00;
	localparam int          UEBC_BIT_USB_FULL    = 7;
	localparam int          UEBC_BIT_CPU_FULL    = 6;
	localparam int          UEBC_BIT_WAY         = 5;
	localparam int          UEBC_BIT_STATUS_ACK  = 4;
	localparam int          UEBC_BIT_PRED_RD     = 3;
	localparam int          UEBC_BIT_PRED_WR     = 2;
	localparam int          UEBC_BIT_CLEAR       = 1;
	localparam int          UEBC_BIT_HANDOFF     = 0;
	localparam int          UEBC_BIT_HALT        = 7;
	localparam int          UEBC_BIT_IRQ_GATE    = 6;
	localparam int          UEBC_BIT_SOF_FLUSH   = 5;
	localparam int          UEBC_BIT_AUTO_STEP   = 4;
	localparam int          UEBC_BIT_DOUBLE_BUF  = 3;
	localparam int          UEBC_FIFO_DEPTH      = 8;
	typedef enum logic [2:0] {
		UEBC_MEM_IDLE  = 3'b001,
		UEBC_MEM_FETCH = 3'b010,
		UEBC_MEM_STORE = 3'b100
	} uebc_mem_state_t;
endpackage : uebc_pkg

// file: verilog/uebc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module uebc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic [WIDTH-1:0]      outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic [AW:0]      count_r, count_nxt;
	logic             doWr, doRd;

	// Full and empty follow the occupancy count
	assign inReady  = (count_r != (AW+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData  = mem[rdPtr_r];
	assign doWr     = inValid && inReady;
	assign doRd     = outValid && outReady;

	always_comb begin
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		count_nxt = count_r;
		if (doWr) begin
			wrPtr_nxt = (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + AW'(1);
		end
		if (doRd) begin
			rdPtr_nxt = (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + AW'(1);
		end
		if (doWr && !doRd) begin
			count_nxt = count_r + (AW+1)'(1);
		end else if (doRd && !doWr) begin
			count_nxt = count_r - (AW+1)'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (doWr) begin
			mem[wrPtr_r] <= inData;
		end
	end
endmodule : uebc_fifo
`default_nettype wire

// file: verilog/uebc_endpoint_ctrl.sv
// What this block does
// [RULE_01] Five identical endpoint control and status register sets, endpoints zero to four.
// [RULE_02] Halt bit set means the endpoint is stalled; clear means normal.
// [RULE_03] Endpoint zero halt clears itself on the next setup token.
// [RULE_04] Endpoint combined interrupt raised only while its interrupt gate is set.
// [RULE_05] With autoflush on, frame start hands off the CPU-side buffer.
// [RULE_06] Auto-step advances the access offset after each data window access.
// [RULE_07] Every offset change fetches the memory byte into the data window.
// [RULE_08] Double buffer select picks dual buffers when set, single when clear.
// [RULE_09] Software writes the bank select register before banked accesses.
// [RULE_10] Status bit 7 reports the USB-side buffer full flag.
// [RULE_11] Status bit 6 reports the CPU-side buffer full flag.
// [RULE_12] Status bit 5 records the last transfer direction.
// [RULE_13] Status ack enable makes next status phase ACK unless halted.
// [RULE_14] Successful status phase clears the enable and raises no status request.
// [RULE_15] Status ack enable always reads as zero.
// [RULE_16] Software should halt endpoint zero on a corrupted control transfer.
// [RULE_17] Read prediction sets read direction only while both buffers are empty.
// [RULE_18] Wrong prediction gives no error; observed USB direction wins.
// [RULE_19] Software never combines both predictions, nor either with clear.
// [RULE_20] Write prediction sets write direction under the same empty condition.
// [RULE_21] Clear strobe zeroes offset and both full flags, keeps direction.
// [RULE_22] Clear with status ack enable keeps it set; clear alone resets it.
// [RULE_23] Handoff strobe tags CPU-side buffer full or empty, self-clears.
// [RULE_24] Bank select chooses which endpoint set the shared addresses reach.
`timescale 1ns/100ps
`default_nettype none
module uebc_endpoint_ctrl
	import uebc_pkg::*;
#(
	parameter int NUM_EP   = uebc_pkg::UEBC_NUM_EP,
	parameter int MEM_AW   = 8,
	parameter int FIFO_DEP = uebc_pkg::UEBC_FIFO_DEPTH
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic [7:0]        sfrAddr,
	input  wire logic [7:0]        sfrWrData,
	input  wire logic              sfrWr,
	input  wire logic              sfrRd,
	output logic [7:0]             sfrRdData,
	output logic [MEM_AW-1:0]      memAddr,
	output logic                   memRd,
	output logic                   memWr,
	output logic [7:0]             memWrData,
	input  wire logic [7:0]        memRdData,
	input  wire logic              memRdValid,
	input  wire logic              memWrReady,
	input  wire logic              sofSeen,
	input  wire logic              setupSeen,
	input  wire logic [2:0]        usbEp,
	input  wire logic              usbXferDone,
	input  wire logic              usbXferToHost,
	input  wire logic              usbSideEmpty,
	input  wire logic              statusPhase,
	input  wire logic              statusPhaseOk,
	input  wire logic [NUM_EP-1:0] irqRequestsAny,
	output logic [NUM_EP-1:0]      endpointHalt,
	output logic [NUM_EP-1:0]      doubleBufferSelect,
	output logic [NUM_EP-1:0]      endpointIrq,
	output logic                   statusAck,
	output logic                   statusNack,
	output logic                   statusRequestIrq,
	output logic                   cpuWriteReady
);
	import uebc_pkg::*;

	logic [7:0]        ctrl_r      [NUM_EP];
	logic [7:0]        ctrl_nxt    [NUM_EP];
	logic [NUM_EP-1:0] usbFull_r, usbFull_nxt, cpuFull_r, cpuFull_nxt;
	logic [NUM_EP-1:0] way_r, way_nxt, ackEn_r, ackEn_nxt;
	logic [2:0]        bank_r, bank_nxt;
	logic [MEM_AW-1:0] offset_r, offset_nxt;
	logic [7:0]        window_r, window_nxt;
	logic [7:0]        rdData_r, rdData_nxt;
	logic [NUM_EP-1:0] halt_r, dbl_r, irq_r;
	logic              ack_r, nack_r, sti_r;
	uebc_mem_state_t   mst_r, mst_nxt;
	logic              winWr, winRd, fetchReq;
	logic              fifoValid;
	logic [MEM_AW+7:0] fifoData;
	logic              fifoReady;
	logic              fifoPop;
	logic              fetchPend_r, fetchPend_nxt;

	function automatic logic hitAddr(input logic [7:0] a, input logic [7:0] ref_a);
		hitAddr = (a == ref_a);
	endfunction : hitAddr

	assign winWr    = sfrWr && hitAddr(sfrAddr, UEBC_ADDR_DATA_WIN);
	assign winRd    = sfrRd && hitAddr(sfrAddr, UEBC_ADDR_DATA_WIN);

	// Head leaves the FIFO only when its store lands
	assign fifoPop  = (mst_r == UEBC_MEM_STORE) && memWrReady;

	// CPU writes into USB memory pass through the FIFO
	// Each entry keeps its own offset, since auto-step moves on at once
	uebc_fifo #(
		.WIDTH (MEM_AW + 8),
		.DEPTH (FIFO_DEP)
	) uFifo (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.inData   ({offset_r, sfrWrData}),
		.inValid  (winWr),
		.inReady  (fifoReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (fifoPop)
	);

	// Register file, per endpoint state
	always_comb begin
		bank_nxt   = bank_r;
		offset_nxt = offset_r;
		fetchReq   = 1'b0;
		rdData_nxt = rdData_r;
		usbFull_nxt = usbFull_r;
		cpuFull_nxt = cpuFull_r;
		way_nxt     = way_r;
		ackEn_nxt   = ackEn_r;
		for (int e = 0; e < NUM_EP; e++) begin
			ctrl_nxt[e] = ctrl_r[e];
		end
		if (sfrWr && hitAddr(sfrAddr, UEBC_ADDR_BANK_SEL)) begin
			bank_nxt = sfrWrData[2:0];
		end
		if (sfrWr && hitAddr(sfrAddr, UEBC_ADDR_OFFSET)) begin
			offset_nxt = sfrWrData[MEM_AW-1:0];
			fetchReq   = 1'b1; // [RULE_07]
		end
		for (int e = 0; e < NUM_EP; e++) begin
			logic sel;
			logic handoff;
			logic empties;
			sel     = (bank_r == 3'(e)); // [RULE_24]
			handoff = 1'b0;
			empties = !usbFull_r[e] && !cpuFull_r[e];
			if (sel && (winWr || winRd) && ctrl_r[e][UEBC_BIT_AUTO_STEP]) begin
				offset_nxt = offset_r + MEM_AW'(1); // [RULE_06]
				fetchReq   = 1'b1; // [RULE_07]
			end
			if (sel && sfrWr && hitAddr(sfrAddr, UEBC_ADDR_BUF_CTRL)) begin
				ctrl_nxt[e] = sfrWrData; // [RULE_01]
			end
			if (sofSeen && ctrl_r[e][UEBC_BIT_SOF_FLUSH]) begin
				handoff = 1'b1; // [RULE_05]
			end
			if (sel && sfrWr && hitAddr(sfrAddr, UEBC_ADDR_BUF_STATUS)) begin
				if (sfrWrData[UEBC_BIT_HANDOFF]) begin
					handoff = 1'b1; // [RULE_23]
				end
				if (sfrWrData[UEBC_BIT_STATUS_ACK]) begin
					ackEn_nxt[e] = 1'b1;
				end else if (sfrWrData[UEBC_BIT_CLEAR]) begin
					ackEn_nxt[e] = 1'b0; // [RULE_22]
				end
				if (sfrWrData[UEBC_BIT_CLEAR]) begin
					offset_nxt     = UEBC_RST_OFFSET[MEM_AW-1:0]; // [RULE_21]
					fetchReq       = 1'b1;
					usbFull_nxt[e] = 1'b0;
					cpuFull_nxt[e] = 1'b0;
				end else if (empties && sfrWrData[UEBC_BIT_PRED_RD]) begin
					way_nxt[e] = 1'b1; // [RULE_17]
				end else if (empties && sfrWrData[UEBC_BIT_PRED_WR]) begin
					way_nxt[e] = 1'b0; // [RULE_20]
				end
			end
			if (handoff) begin
				// Toward host the CPU buffer fills, from host it empties
				cpuFull_nxt[e] = way_r[e];
			end
			if (usbXferDone && usbEp == 3'(e)) begin
				way_nxt[e]     = usbXferToHost; // [RULE_18]
				usbFull_nxt[e] = !usbSideEmpty;
			end
			if (e == 0 && setupSeen && usbEp == 3'h0) begin
				ctrl_nxt[e][UEBC_BIT_HALT] = 1'b0; // [RULE_03]
				usbFull_nxt[e] = 1'b0;
				cpuFull_nxt[e] = 1'b0;
				way_nxt[e]     = 1'b0;
			end
			if (statusPhaseOk && usbEp == 3'(e) && ackEn_r[e]) begin
				ackEn_nxt[e] = 1'b0; // [RULE_14]
			end
		end
		if (sfrRd) begin
			rdData_nxt = 8'h00;
			for (int e = 0; e < NUM_EP; e++) begin
				if (bank_r == 3'(e) && hitAddr(sfrAddr, UEBC_ADDR_BUF_STATUS)) begin
					rdData_nxt[UEBC_BIT_USB_FULL] = usbFull_r[e]; // [RULE_10]
					rdData_nxt[UEBC_BIT_CPU_FULL] = cpuFull_r[e]; // [RULE_11]
					rdData_nxt[UEBC_BIT_WAY]      = way_r[e]; // [RULE_12]
					rdData_nxt[UEBC_BIT_STATUS_ACK] = 1'b0; // [RULE_15]
				end
				if (bank_r == 3'(e) && hitAddr(sfrAddr, UEBC_ADDR_BUF_CTRL)) begin
					rdData_nxt = ctrl_r[e];
				end
			end
			if (hitAddr(sfrAddr, UEBC_ADDR_BANK_SEL)) begin
				rdData_nxt = {5'h00, bank_r};
			end
			if (hitAddr(sfrAddr, UEBC_ADDR_DATA_WIN)) begin
				rdData_nxt = window_r;
			end
			if (hitAddr(sfrAddr, UEBC_ADDR_OFFSET)) begin
				rdData_nxt = 8'(offset_r);
			end
		end
	end

	// Memory sequencer: drains FIFO writes, refetches the window
	always_comb begin
		mst_nxt       = mst_r;
		window_nxt    = window_r;
		fetchPend_nxt = fetchPend_r || fetchReq;
		unique case (mst_r)
			UEBC_MEM_IDLE: begin
				if (fifoValid && memWrReady) begin
					mst_nxt = UEBC_MEM_STORE;
				end else if (fetchPend_nxt) begin
					mst_nxt       = UEBC_MEM_FETCH;
					fetchPend_nxt = 1'b0;
				end
			end
			UEBC_MEM_STORE: begin
				if (memWrReady) begin
					mst_nxt       = UEBC_MEM_FETCH;
					fetchPend_nxt = 1'b0;
				end
			end
			UEBC_MEM_FETCH: begin
				if (memRdValid) begin
					window_nxt = memRdData; // [RULE_07]
					mst_nxt    = UEBC_MEM_IDLE;
				end
			end
			default: mst_nxt = UEBC_MEM_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			for (int e = 0; e < NUM_EP; e++) begin
				ctrl_r[e] <= UEBC_RST_BUF_CTRL;
			end
			usbFull_r <= '0;
			cpuFull_r <= '0;
			way_r     <= {NUM_EP{UEBC_RST_BUF_STATUS[UEBC_BIT_WAY]}};
			ackEn_r   <= '0;
			bank_r    <= UEBC_RST_BANK_SEL[2:0];
			offset_r  <= UEBC_RST_OFFSET[MEM_AW-1:0];
			window_r  <= 8'h00;
			rdData_r  <= 8'h00;
			mst_r     <= UEBC_MEM_IDLE;
			fetchPend_r <= 1'b0;
		end else begin
			for (int e = 0; e < NUM_EP; e++) begin
				ctrl_r[e] <= ctrl_nxt[e];
			end
			usbFull_r <= usbFull_nxt;
			cpuFull_r <= cpuFull_nxt;
			way_r     <= way_nxt;
			ackEn_r   <= ackEn_nxt;
			bank_r    <= bank_nxt;
			offset_r  <= offset_nxt;
			window_r  <= window_nxt;
			rdData_r  <= rdData_nxt;
			mst_r     <= mst_nxt;
			fetchPend_r <= fetchPend_nxt;
		end
	end

	// Registered outputs toward serial engine and interrupt logic
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			halt_r <= '0;
			dbl_r  <= '0;
			irq_r  <= '0;
			ack_r  <= 1'b0;
			nack_r <= 1'b0;
			sti_r  <= 1'b0;
		end else begin
			for (int e = 0; e < NUM_EP; e++) begin
				halt_r[e] <= ctrl_nxt[e][UEBC_BIT_HALT]; // [RULE_02]
				dbl_r[e]  <= ctrl_nxt[e][UEBC_BIT_DOUBLE_BUF]; // [RULE_08]
				irq_r[e]  <= irqRequestsAny[e] && ctrl_r[e][UEBC_BIT_IRQ_GATE]; // [RULE_04]
			end
			ack_r  <= statusPhase && usbEp < 3'(NUM_EP) && ackEn_r[usbEp] && !halt_r[usbEp]; // [RULE_13]
			nack_r <= statusPhase && usbEp < 3'(NUM_EP) && !ackEn_r[usbEp] && !halt_r[usbEp];
			sti_r  <= statusPhase && usbEp < 3'(NUM_EP) && !ackEn_r[usbEp] && !halt_r[usbEp]; // [RULE_14]
		end
	end

	assign sfrRdData          = rdData_r;
	assign memAddr            = (mst_r == UEBC_MEM_STORE) ? fifoData[MEM_AW+7:8] : offset_r;
	assign memRd              = (mst_r == UEBC_MEM_FETCH);
	assign memWr              = (mst_r == UEBC_MEM_STORE);
	assign memWrData          = fifoData[7:0];
	assign endpointHalt       = halt_r;
	assign doubleBufferSelect = dbl_r;
	assign endpointIrq        = irq_r;
	assign statusAck          = ack_r;
	assign statusNack         = nack_r;
	assign statusRequestIrq   = sti_r;
	assign cpuWriteReady      = fifoReady;
endmodule : uebc_endpoint_ctrl
`default_nettype wire

// file: bench/uebc_usb_mem.sv
`timescale 1ns/100ps
`default_nettype none
module uebc_usb_mem (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [7:0] memAddr,
	input  wire logic       memRd,
	input  wire logic       memWr,
	input  wire logic [7:0] memWrData,
	input  wire logic       holdOff,
	input  wire logic       slowRead,
	output logic [7:0]      memRdData,
	output logic            memRdValid,
	output logic            memWrReady
);
	logic [7:0] mem [256];
	logic [3:0] waitCnt;
	int         storeCount;
	assign memWrReady = !holdOff;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
		storeCount = 0;
		memRdData = 8'h00;
	end
	// Fetch answer after one or six cycles; stale data toggles every cycle
	always @(posedge mclk) begin
		memRdValid <= 1'b0;
		memRdData <= ~memRdData;
		waitCnt <= 4'h0;
		if (rst_n && memRd && !memRdValid) begin
			waitCnt <= waitCnt + 4'h1;
			if (waitCnt >= (slowRead ? 4'h5 : 4'h0)) begin
				memRdValid <= 1'b1;
				memRdData <= mem[memAddr];
				waitCnt <= 4'h0;
			end
		end
		if (memWr && memWrReady) begin
			mem[memAddr] <= memWrData;
			storeCount <= storeCount + 1;
		end
	end
endmodule : uebc_usb_mem
`default_nettype wire

// file: bench/uebc_ctrl_checker_properties.sv
`timescale 1ns/100ps
`default_nettype none
module uebc_ctrl_checker #(
	parameter int NUM_EP = uebc_pkg::UEBC_NUM_EP,
	parameter int MEM_AW = 8
) (
	input wire logic              mclk,
	input wire logic              rst_n,
	input wire logic [7:0]        sfrAddr,
	input wire logic [7:0]        sfrWrData,
	input wire logic              sfrWr,
	input wire logic              sfrRd,
	input wire logic [7:0]        sfrRdData,
	input wire logic [MEM_AW-1:0] memAddr,
	input wire logic              memRd,
	input wire logic              setupSeen,
	input wire logic [2:0]        usbEp,
	input wire logic              statusPhase,
	input wire logic [NUM_EP-1:0] irqRequestsAny,
	input wire logic [NUM_EP-1:0] endpointHalt,
	input wire logic [NUM_EP-1:0] endpointIrq,
	input wire logic              statusAck,
	input wire logic              statusNack,
	input wire logic              statusRequestIrq
);
	import uebc_pkg::*;
	logic [7:0] bankSel_r;
	logic [7:0] bankSel_nxt;
	logic [NUM_EP-1:0] gate_r;
	logic [NUM_EP-1:0] gate_nxt;
	always_comb begin
		bankSel_nxt = bankSel_r;
		gate_nxt    = gate_r;
		if (sfrWr && sfrAddr == UEBC_ADDR_BANK_SEL) begin
			bankSel_nxt = sfrWrData;
		end
		if (sfrWr && sfrAddr == UEBC_ADDR_BUF_CTRL && bankSel_r < NUM_EP) begin
			gate_nxt[bankSel_r[2:0]] = sfrWrData[UEBC_BIT_IRQ_GATE];
		end
	end
	always_ff @(posedge mclk) begin
		bankSel_r <= rst_n ? bankSel_nxt : 8'h00;
		gate_r    <= rst_n ? gate_nxt : '0;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_halt_write;
		sfrWr && sfrAddr == UEBC_ADDR_BUF_CTRL && bankSel_r < NUM_EP && !setupSeen
			|=> endpointHalt[bankSel_r[2:0]] == $past(sfrWrData[UEBC_BIT_HALT]);
	endproperty
	a_halt_write: assert property (p_halt_write) else $error("halt bit not taken from write");
	property p_irq_gate;
		1'b1 |=> endpointIrq == ($past(irqRequestsAny) & $past(gate_r));
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("endpoint irq not gated by enable");
	property p_setup_clear;
		setupSeen && usbEp == 3'h0 && !sfrWr |=> !endpointHalt[0];
	endproperty
	a_setup_clear: assert property (p_setup_clear) else $error("setup left halt set");
	property p_ack_cause;
		statusAck |-> $past(statusPhase) && !statusNack;
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without status phase");
	property p_halt_silent;
		statusPhase && usbEp < NUM_EP && endpointHalt[usbEp] |=> !statusAck && !statusNack;
	endproperty
	a_halt_silent: assert property (p_halt_silent) else $error("halted endpoint answered");
	property p_sti_nack;
		statusAck || statusNack |-> statusRequestIrq == statusNack;
	endproperty
	a_sti_nack: assert property (p_sti_nack) else $error("status request mismatch");
	property p_status_read;
		sfrRd && sfrAddr == UEBC_ADDR_BUF_STATUS |=> sfrRdData[4:0] == 5'h00;
	endproperty
	a_status_read: assert property (p_status_read) else $error("write-only bits read set");
	property p_offset_fetch;
		sfrWr && sfrAddr == UEBC_ADDR_OFFSET && sfrWrData != memAddr |-> ##[1:8] memRd;
	endproperty
	a_offset_fetch: assert property (p_offset_fetch) else $error("no fetch after offset change");
endmodule : uebc_ctrl_checker
bind uebc_endpoint_ctrl uebc_ctrl_checker #(.NUM_EP(NUM_EP), .MEM_AW(MEM_AW)) uebc_ctrl_checker_inst (.mclk, .rst_n,
	.sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrRdData, .memAddr, .memRd, .setupSeen, .usbEp, .statusPhase,
	.irqRequestsAny, .endpointHalt, .endpointIrq, .statusAck, .statusNack, .statusRequestIrq);
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import uebc_pkg::*;
	logic       mclk, rst_n, sfrWr, sfrRd, usbXferToHost, usbSideEmpty, holdOff, slowRead;
	logic       memRd, memWr, memRdValid, memWrReady, statusAck, statusNack, statusRequestIrq, cpuWriteReady;
	logic       sofSeen, setupSeen, usbXferDone, statusPhase, statusPhaseOk;
	logic [7:0] sfrAddr, sfrWrData, sfrRdData, memAddr, memWrData, memRdData;
	logic [4:0] evt, irqRequestsAny, endpointHalt, doubleBufferSelect, endpointIrq;
	logic [2:0] usbEp;
	int         errors, n_tests, stores, k;
	assign {sofSeen, setupSeen, usbXferDone, statusPhase, statusPhaseOk} = evt;
	uebc_endpoint_ctrl uebc_endpoint_ctrl_inst (.mclk, .rst_n, .sfrAddr, .sfrWrData, .sfrWr, .sfrRd, .sfrRdData,
		.memAddr, .memRd, .memWr, .memWrData, .memRdData, .memRdValid, .memWrReady, .sofSeen, .setupSeen, .usbEp,
		.usbXferDone, .usbXferToHost, .usbSideEmpty, .statusPhase, .statusPhaseOk, .irqRequestsAny, .endpointHalt,
		.doubleBufferSelect, .endpointIrq, .statusAck, .statusNack, .statusRequestIrq, .cpuWriteReady);
	uebc_usb_mem uebc_usb_mem_inst (.mclk, .rst_n, .memAddr, .memRd, .memWr, .memWrData, .holdOff, .slowRead,
		.memRdData, .memRdValid, .memWrReady);
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) #1;
		{sfrWr, sfrAddr, sfrWrData} = {1'b1, a, d};
		@(posedge mclk) #1;
		sfrWr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge mclk) #1;
		{sfrRd, sfrAddr} = {1'b1, a};
		@(posedge mclk) #1;
		sfrRd = 1'b0;
		chk(sfrRdData & m, e);
	endtask : rd
	task automatic fire(input logic [4:0] e, input logic [2:0] ep);
		@(posedge mclk) #1;
		{evt, usbEp} = {e, ep};
		@(posedge mclk) #1;
		evt = 5'h00;
	endtask : fire
	task automatic stat(input logic [2:0] ep, input logic [7:0] e);
		fire(5'h02, ep);
		chk({5'h00, statusAck, statusNack, statusRequestIrq}, e);
	endtask : stat
	task automatic waitFetch();
		for (k = 0; k < 40 && memRdValid !== 1'b1; k++) @(posedge mclk) #1;
		chk({7'h00, memRdValid}, 8'h01);
		@(posedge mclk) #1;
	endtask : waitFetch
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#100000;
		errors++;
		end_of_test();
	end
	initial begin
		{rst_n, sfrWr, sfrRd, usbXferToHost, usbSideEmpty, holdOff, slowRead} = 7'h00;
		{sfrAddr, sfrWrData, evt, irqRequestsAny, usbEp} = 29'h0;
		repeat (3) @(posedge mclk);
		#1 rst_n = 1'b1;
		rd(UEBC_ADDR_BUF_STATUS, UEBC_RST_BUF_STATUS, 8'hff);
		rd(UEBC_ADDR_BUF_CTRL, UEBC_RST_BUF_CTRL, 8'hff);
		rd(8'h00, 8'h00, 8'hff);
		for (int i = 0; i < 5; i++) begin
			wr(UEBC_ADDR_BANK_SEL, 8'(i));
			wr(UEBC_ADDR_BUF_CTRL, i[0] ? 8'h08 : 8'h80);
		end
		chk({3'h0, endpointHalt}, 8'h15);
		chk({3'h0, doubleBufferSelect}, 8'h0a);
		for (int i = 0; i < 5; i++) begin
			wr(UEBC_ADDR_BANK_SEL, 8'(i));
			rd(UEBC_ADDR_BUF_CTRL, i[0] ? 8'h08 : 8'h80, 8'hff);
		end
		fire(5'h08, 3'h2);
		chk({3'h0, endpointHalt}, 8'h15);
		fire(5'h08, 3'h0);
		chk({3'h0, endpointHalt}, 8'h14);
		stat(3'h1, 8'h03);
		wr(UEBC_ADDR_BANK_SEL, 8'h01);
		wr(UEBC_ADDR_BUF_STATUS, 8'h10);
		rd(UEBC_ADDR_BUF_STATUS, 8'h00, 8'h10);
		stat(3'h1, 8'h04);
		fire(5'h01, 3'h1);
		stat(3'h1, 8'h03);
		wr(UEBC_ADDR_BUF_STATUS, 8'h12);
		stat(3'h1, 8'h04);
		fire(5'h01, 3'h1);
		wr(UEBC_ADDR_BUF_STATUS, 8'h10);
		wr(UEBC_ADDR_BUF_STATUS, 8'h02);
		stat(3'h1, 8'h03);
		wr(UEBC_ADDR_BANK_SEL, 8'h02);
		wr(UEBC_ADDR_BUF_STATUS, 8'h10);
		stat(3'h2, 8'h00);
		irqRequestsAny = 5'h1f;
		wr(UEBC_ADDR_BANK_SEL, 8'h03);
		wr(UEBC_ADDR_BUF_CTRL, 8'h48);
		repeat (2) @(posedge mclk) #1;
		chk({3'h0, endpointIrq}, 8'h08);
		irqRequestsAny = 5'h17;
		repeat (2) @(posedge mclk) #1;
		chk({3'h0, endpointIrq}, 8'h00);
		wr(UEBC_ADDR_BANK_SEL, 8'h04);
		wr(UEBC_ADDR_BUF_STATUS, 8'h01);
		rd(UEBC_ADDR_BUF_STATUS, 8'h60, 8'hff);
		wr(UEBC_ADDR_BUF_STATUS, 8'h04);
		rd(UEBC_ADDR_BUF_STATUS, 8'h60, 8'hff);
		wr(UEBC_ADDR_BUF_STATUS, 8'h02);
		rd(UEBC_ADDR_BUF_STATUS, 8'h20, 8'hff);
		wr(UEBC_ADDR_BUF_STATUS, 8'h04);
		rd(UEBC_ADDR_BUF_STATUS, 8'h00, 8'hff);
		wr(UEBC_ADDR_BUF_STATUS, 8'h08);
		rd(UEBC_ADDR_BUF_STATUS, 8'h20, 8'hff);
		wr(UEBC_ADDR_BUF_CTRL, 8'h20);
		fire(5'h10, 3'h4);
		rd(UEBC_ADDR_BUF_STATUS, 8'h60, 8'hff);
		wr(UEBC_ADDR_BANK_SEL, 8'h03);
		rd(UEBC_ADDR_BUF_STATUS, 8'h20, 8'hff);
		wr(UEBC_ADDR_BANK_SEL, 8'h04);
		wr(UEBC_ADDR_BUF_STATUS, 8'h02);
		usbSideEmpty = 1'b1;
		fire(5'h04, 3'h4);
		rd(UEBC_ADDR_BUF_STATUS, 8'h00, 8'h20);
		{usbXferToHost, usbSideEmpty} = 2'b10;
		fire(5'h04, 3'h4);
		rd(UEBC_ADDR_BUF_STATUS, 8'ha0, 8'ha0);
		wr(UEBC_ADDR_BUF_CTRL, 8'h10);
		wr(UEBC_ADDR_OFFSET, 8'h10);
		waitFetch();
		rd(UEBC_ADDR_DATA_WIN, 8'h4a, 8'hff);
		waitFetch();
		rd(UEBC_ADDR_DATA_WIN, 8'h4b, 8'hff);
		slowRead = 1'b1;
		wr(UEBC_ADDR_OFFSET, 8'h20);
		waitFetch();
		rd(UEBC_ADDR_DATA_WIN, 8'h7a, 8'hff);
		{slowRead, holdOff} = 2'b01;
		stores = uebc_usb_mem_inst.storeCount;
		for (int i = 0; i < UEBC_FIFO_DEPTH; i++) wr(UEBC_ADDR_DATA_WIN, 8'hc0 + 8'(i));
		chk({7'h00, cpuWriteReady}, 8'h00);
		holdOff = 1'b0;
		for (k = 0; k < 200 && uebc_usb_mem_inst.storeCount - stores < 8; k++) @(posedge mclk) #1;
		chk(8'(uebc_usb_mem_inst.storeCount - stores), 8'h08);
		chk(uebc_usb_mem_inst.mem[8'h21], 8'hc0);
		chk(uebc_usb_mem_inst.mem[8'h28], 8'hc7);
		chk({7'h00, cpuWriteReady}, 8'h01);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
